// ==== logic/pdts_params.svh ====
// Register offsets, field positions, codes and reset values of the toggle status and event latch block
`ifndef PDTS_PARAMS_SVH
`define PDTS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PDTS_ADDR_MASK_A      8'h0E
`define PDTS_ADDR_MASK_B      8'h0F
`define PDTS_ADDR_STATUS      8'h3D
`define PDTS_ADDR_LATCH_A     8'h3E
`define PDTS_ADDR_LATCH_B     8'h3F

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define PDTS_DATA_W           8
`define PDTS_LATCH_A_W        8
`define PDTS_LATCH_B_W        1
`define PDTS_RESET_BYTE       8'h00
`define PDTS_RESET_RX_TYPE    3'h0

// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define PDTS_TOG_LSB          3
`define PDTS_TOG_MSB          5
`define PDTS_RXT_LSB          0
`define PDTS_RXT_MSB          2
`define PDTS_RXT_SOP          0
`define PDTS_RXT_SOP1_DBG     1
`define PDTS_RXT_SOP2_DBG     2

// ----------------------------------------------------------------
// Toggle status codes
// ----------------------------------------------------------------
`define PDTS_TOG_RUNNING      3'h0
`define PDTS_TOG_SRC_CC1      3'h1
`define PDTS_TOG_SRC_CC2      3'h2
`define PDTS_TOG_SNK_CC1      3'h5
`define PDTS_TOG_SNK_CC2      3'h6
`define PDTS_TOG_AUDIO        3'h7

// ----------------------------------------------------------------
// Latch A and latch B bit positions
// ----------------------------------------------------------------
`define PDTS_IA_OCP_TEMP      7
`define PDTS_IA_TOG_DONE      6
`define PDTS_IA_SOFT_FAIL     5
`define PDTS_IA_RETRY_FAIL    4
`define PDTS_IA_HARD_SENT     3
`define PDTS_IA_TX_ACKED      2
`define PDTS_IA_SOFT_RX       1
`define PDTS_IA_HARD_RX       0
`define PDTS_IB_ACK_SENT      0

`endif

// ==== logic/pdts_pkg.sv ====
// Types shared by the toggle status and event latch block
package pdts_pkg;

	typedef enum logic [2:0] {
		PDTS_RES_SRC_CC1,
		PDTS_RES_SRC_CC2,
		PDTS_RES_SNK_CC1,
		PDTS_RES_SNK_CC2,
		PDTS_RES_AUDIO
	} pdts_tog_result_type;

	typedef enum logic [1:0] {
		PDTS_TOG_OFF,
		PDTS_TOG_RUN,
		PDTS_TOG_STOP
	} pdts_tog_state_type;

	typedef enum logic [1:0] {
		PDTS_SOP,
		PDTS_SOP1_DBG,
		PDTS_SOP2_DBG,
		PDTS_SOP_OTHER
	} pdts_sop_kind_type;

	typedef struct packed {
		logic              stored;
		pdts_sop_kind_type kind;
	} pdts_rx_type;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pdts_reg_req_type;

	typedef struct packed {
		logic ocp;
		logic over_temp;
		logic soft_fail;
		logic retry_fail;
		logic hard_sent;
		logic tx_acked;
		logic soft_rx;
		logic hard_rx;
		logic ack_sent;
	} pdts_event_type;

endpackage

// ==== logic/pdts_event_latch.sv ====
// Read-to-clear event latch with per-bit mask and pending output
`timescale 1ns/1ns
`include "pdts_params.svh"
module pdts_event_latch #(
	parameter int WIDTH = `PDTS_LATCH_A_W
) (
	input  wire logic             clk_i,     // System clock
	input  wire logic             sys_rst_i, // Synchronous reset
	input  wire logic [WIDTH-1:0] set_i,     // Event strobes
	input  wire logic             clr_i,     // Register read strobe
	input  wire logic [WIDTH-1:0] mask_i,    // 1 blocks the cause
	output logic      [WIDTH-1:0] latch_o,   // Latched causes
	output logic                  pend_o     // Unmasked cause present
);

	logic [WIDTH-1:0] latch_q;

	// ----------------------------------------------------------------
	// Per-bit latches
	// ----------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < WIDTH; b++) begin : g_bit
			always_ff @(posedge clk_i) begin
				if (sys_rst_i)
					latch_q[b] <= 1'b0;
				else if (set_i[b])
					latch_q[b] <= 1'b1;
				else if (clr_i)
					latch_q[b] <= 1'b0;
			end
		end
	endgenerate

	assign latch_o = latch_q;
	assign pend_o  = |(latch_q & ~mask_i);

endmodule

// ==== logic/pdts_rx_type_track.sv ====
// Start-of-packet type flags of the last packet stored in the receive queue
`timescale 1ns/1ns
`include "pdts_params.svh"
module pdts_rx_type_track
	import pdts_pkg::*;
(
	input  wire logic        clk_i,     // System clock
	input  wire logic        sys_rst_i, // Synchronous reset
	input  wire pdts_rx_type rx_i,      // Packet stored strobe and kind
	output logic [2:0]       flags_o    // One-hot type flags
);

	logic [2:0] flags_q;
	logic [2:0] flags_d;

	assign flags_d[`PDTS_RXT_SOP]      = (rx_i.kind == PDTS_SOP);
	assign flags_d[`PDTS_RXT_SOP1_DBG] = (rx_i.kind == PDTS_SOP1_DBG);
	assign flags_d[`PDTS_RXT_SOP2_DBG] = (rx_i.kind == PDTS_SOP2_DBG);

	// Non-debug primes are flagged elsewhere, so all three read zero then
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			flags_q <= `PDTS_RESET_RX_TYPE;
		else if (rx_i.stored)
			flags_q <= flags_d;
	end

	assign flags_o = flags_q;

endmodule

// ==== logic/pdts_top.sv ====
// Toggle result status, received packet type and PD event interrupt latches
`timescale 1ns/1ns
`include "pdts_params.svh"
module pdts_top
	import pdts_pkg::*;
(
	input  wire logic                 clk_i,          // System clock, 50 MHz
	input  wire logic                 sys_rst_i,      // Synchronous reset, active high
	input  wire pdts_reg_req_type     req_i,          // Register read/write request
	input  wire logic                 tog_enable_i,   // Software toggle enable level
	input  wire logic                 tog_settle_i,   // Toggle engine settled pulse
	input  wire pdts_tog_result_type  tog_result_i,   // Result with the settle pulse
	input  wire pdts_rx_type          rx_i,           // Packet stored in receive queue
	input  wire pdts_event_type       events_i,       // PD event strobes
	output logic [`PDTS_DATA_W-1:0]   rd_data_o,      // Read data
	output logic                      rd_valid_o,     // Read data valid pulse
	output logic                      irq_n_o,        // Interrupt, active low
	output pdts_tog_result_type       stop_state_o,   // Stop state for the engine
	output logic                      stopped_o       // Engine in a stop state
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Status code of a settle result
	function automatic logic [2:0] tog_code(input pdts_tog_result_type res);
		logic [2:0] code;
		code = `PDTS_TOG_RUNNING;
		unique case (res)
			PDTS_RES_SRC_CC1: code = `PDTS_TOG_SRC_CC1;
			PDTS_RES_SRC_CC2: code = `PDTS_TOG_SRC_CC2;
			PDTS_RES_SNK_CC1: code = `PDTS_TOG_SNK_CC1;
			PDTS_RES_SNK_CC2: code = `PDTS_TOG_SNK_CC2;
			PDTS_RES_AUDIO:   code = `PDTS_TOG_AUDIO;
			default:          code = `PDTS_TOG_RUNNING;
		endcase
		return code;
	endfunction

	// Engine stop state for a settle result
	function automatic pdts_tog_result_type stop_of(input pdts_tog_result_type res);
		pdts_tog_result_type st;
		st = res;
		if (res == PDTS_RES_AUDIO)
			st = PDTS_RES_SRC_CC1;
		return st;
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pdts_tog_state_type          tog_state_q;
	pdts_tog_state_type          tog_state_d;
	logic [2:0]                  tog_code_q;
	logic [2:0]                  tog_code_d;
	pdts_tog_result_type         stop_state_q;
	pdts_tog_result_type         stop_state_d;
	logic                        stopped_q;
	logic                        tog_done;
	logic [2:0]                  rx_flags;
	logic [`PDTS_LATCH_A_W-1:0]  mask_a_q;
	// Mask B guards the single cause that latch B carries
	logic [`PDTS_LATCH_B_W-1:0]  mask_b_q;
	logic [`PDTS_LATCH_A_W-1:0]  set_a;
	logic [`PDTS_LATCH_B_W-1:0]  set_b;
	logic [`PDTS_LATCH_A_W-1:0]  latch_a;
	logic [`PDTS_LATCH_B_W-1:0]  latch_b;
	logic                        pend_a;
	logic                        pend_b;
	logic                        sel_status;
	logic                        sel_latch_a;
	logic                        sel_latch_b;
	logic                        sel_mask_a;
	logic                        sel_mask_b;
	logic                        rd_latch_a;
	logic                        rd_latch_b;
	logic [`PDTS_DATA_W-1:0]     status_byte;
	logic [`PDTS_DATA_W-1:0]     rd_mux;
	logic [`PDTS_DATA_W-1:0]     rd_data_q;
	logic                        rd_valid_q;
	logic                        irq_n_q;

	// ----------------------------------------------------------------
	// Toggle result tracking
	// ----------------------------------------------------------------
	// A settle pulse only counts while toggling is enabled and running
	// A settle in the first enabled cycle is dropped: the engine is still idle then
	assign tog_done = (tog_state_q == PDTS_TOG_RUN) && tog_enable_i && tog_settle_i;

	always_comb begin
		tog_state_d  = tog_state_q;
		tog_code_d   = tog_code_q;
		stop_state_d = stop_state_q;
		unique case (tog_state_q)
			PDTS_TOG_OFF: begin
				if (tog_enable_i) begin
					tog_state_d = PDTS_TOG_RUN;
					tog_code_d  = `PDTS_TOG_RUNNING;
				end
			end
			PDTS_TOG_RUN: begin
				if (!tog_enable_i) begin
					tog_state_d = PDTS_TOG_OFF;
				end else if (tog_settle_i) begin
					tog_state_d  = PDTS_TOG_STOP;
					tog_code_d   = tog_code(tog_result_i);
					stop_state_d = stop_of(tog_result_i);
				end
			end
			PDTS_TOG_STOP: begin
				// Result holds until software drops the enable and restarts
				if (!tog_enable_i)
					tog_state_d = PDTS_TOG_OFF;
			end
			default: begin
				// Unused state code falls back to idle rather than locking up
				tog_state_d = PDTS_TOG_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tog_state_q  <= PDTS_TOG_OFF;
			tog_code_q   <= `PDTS_TOG_RUNNING;
			stop_state_q <= PDTS_RES_SRC_CC1;
			stopped_q    <= 1'b0;
		end else begin
			tog_state_q  <= tog_state_d;
			tog_code_q   <= tog_code_d;
			stop_state_q <= stop_state_d;
			// Taken from the next state so the flag and the code move together
			stopped_q    <= (tog_state_d == PDTS_TOG_STOP);
		end
	end

	assign stop_state_o = stop_state_q;
	assign stopped_o    = stopped_q;

	// ----------------------------------------------------------------
	// Received packet type
	// ----------------------------------------------------------------
	pdts_rx_type_track u_rx_type (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.rx_i      (rx_i),
		.flags_o   (rx_flags)
	);

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	assign sel_status  = (req_i.addr == `PDTS_ADDR_STATUS);
	assign sel_latch_a = (req_i.addr == `PDTS_ADDR_LATCH_A);
	assign sel_latch_b = (req_i.addr == `PDTS_ADDR_LATCH_B);
	assign sel_mask_a  = (req_i.addr == `PDTS_ADDR_MASK_A);
	assign sel_mask_b  = (req_i.addr == `PDTS_ADDR_MASK_B);
	assign rd_latch_a  = req_i.rd && sel_latch_a;
	assign rd_latch_b  = req_i.rd && sel_latch_b;

	// Reserved status bits read as zero
	always_comb begin
		status_byte = `PDTS_RESET_BYTE;
		status_byte[`PDTS_TOG_MSB:`PDTS_TOG_LSB] = tog_code_q;
		status_byte[`PDTS_RXT_MSB:`PDTS_RXT_LSB] = rx_flags;
	end

	// Unmapped offsets read as zero; mask A reads back what was written, mask B only bit 0 of it
	always_comb begin
		rd_mux = `PDTS_RESET_BYTE;
		if (sel_status)
			rd_mux = status_byte;
		else if (sel_latch_a)
			rd_mux = latch_a;
		else if (sel_latch_b)
			rd_mux = {{(`PDTS_DATA_W-`PDTS_LATCH_B_W){1'b0}}, latch_b};
		else if (sel_mask_a)
			rd_mux = mask_a_q;
		else if (sel_mask_b)
			rd_mux = {{(`PDTS_DATA_W-`PDTS_LATCH_B_W){1'b0}}, mask_b_q};
	end

	// ----------------------------------------------------------------
	// Mask registers
	// ----------------------------------------------------------------
	// Writes to read-only or clear-on-read offsets are dropped
	// Masks gate only the pin; a masked cause still latches for polling
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mask_a_q <= `PDTS_RESET_BYTE;
			mask_b_q <= '0;
		end else if (req_i.wr) begin
			if (sel_mask_a)
				mask_a_q <= req_i.wdata;
			if (sel_mask_b)
				mask_b_q <= req_i.wdata[`PDTS_LATCH_B_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Event latches
	// ----------------------------------------------------------------
	// Over-current and heat share one bit; software tells them apart elsewhere
	// over-current or heat
	assign set_a[`PDTS_IA_OCP_TEMP]   = events_i.ocp | events_i.over_temp;
	assign set_a[`PDTS_IA_TOG_DONE]   = tog_done;
	assign set_a[`PDTS_IA_SOFT_FAIL]  = events_i.soft_fail;
	assign set_a[`PDTS_IA_RETRY_FAIL] = events_i.retry_fail;
	assign set_a[`PDTS_IA_HARD_SENT]  = events_i.hard_sent;
	assign set_a[`PDTS_IA_TX_ACKED]   = events_i.tx_acked;
	assign set_a[`PDTS_IA_SOFT_RX]    = events_i.soft_rx;
	assign set_a[`PDTS_IA_HARD_RX]    = events_i.hard_rx;
	assign set_b[`PDTS_IB_ACK_SENT]   = events_i.ack_sent;

	pdts_event_latch #(
		.WIDTH (`PDTS_LATCH_A_W)
	) u_latch_a (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.set_i     (set_a),
		.clr_i     (rd_latch_a),
		.mask_i    (mask_a_q),
		.latch_o   (latch_a),
		.pend_o    (pend_a)
	);

	pdts_event_latch #(
		.WIDTH (`PDTS_LATCH_B_W)
	) u_latch_b (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.set_i     (set_b),
		.clr_i     (rd_latch_b),
		.mask_i    (mask_b_q),
		.latch_o   (latch_b),
		.pend_o    (pend_b)
	);

	// ----------------------------------------------------------------
	// Read data and interrupt outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rd_data_q  <= `PDTS_RESET_BYTE;
			rd_valid_q <= 1'b0;
			irq_n_q    <= 1'b1;
		end else begin
			rd_valid_q <= req_i.rd;
			// Data holds between reads so a slow host may sample it late
			if (req_i.rd)
				rd_data_q <= rd_mux;
			// Registered so the pin cannot glitch while a latch and its mask change together
			// any unmasked latch drives the interrupt
			irq_n_q    <= ~(pend_a | pend_b);
		end
	end

	// ----------------------------------------------------------------
	// Port drive
	// ----------------------------------------------------------------
	// Every output is a flop, so pad timing never depends on decode depth
	assign rd_data_o  = rd_data_q;
	assign rd_valid_o = rd_valid_q;
	assign irq_n_o    = irq_n_q;

endmodule

// ==== verif/pdts_far_model.sv ====
// Behavioural toggle engine, PHY event source and receive queue writer
`timescale 1ns/1ns
module pdts_far_model
	import pdts_pkg::*;
(
	input  wire logic           clk_i,        // System clock
	output pdts_event_type      events_o,     // Event strobes
	output logic                tog_settle_o, // Settle pulse
	output pdts_tog_result_type tog_result_o, // Result with settle
	output pdts_rx_type         rx_o          // Packet stored
);
	initial begin
		events_o = '0;
		tog_settle_o = 1'b0;
		tog_result_o = PDTS_RES_SNK_CC2;
		rx_o = '0;
	end

	// Called just after a falling edge; strobes last one cycle
	task automatic pulse(input logic [8:0] ev);
		events_o = ev;
		@(negedge clk_i);
		events_o = '0;
	endtask

	// Result is only meaningful with the pulse, so it moves away afterwards
	task automatic settle(input pdts_tog_result_type res);
		tog_settle_o = 1'b1;
		tog_result_o = res;
		@(negedge clk_i);
		tog_settle_o = 1'b0;
		tog_result_o = (res == PDTS_RES_AUDIO) ? PDTS_RES_SRC_CC1 : PDTS_RES_AUDIO;
	endtask

	task automatic store(input pdts_sop_kind_type kind);
		rx_o = '{1'b1, kind};
		@(negedge clk_i);
		rx_o = '{1'b0, pdts_sop_kind_type'(~kind)};
	endtask
endmodule

// ==== verif/pdts_top_sva.sv ====
// Concurrent checks on the ports of the toggle status and event latch block
`timescale 1ns/1ns
`include "pdts_params.svh"
module pdts_top_sva
	import pdts_pkg::*;
(
	input wire logic                    clk_i,        // System clock
	input wire logic                    sys_rst_i,    // Synchronous reset
	input wire pdts_reg_req_type        req_i,        // Register request
	input wire logic                    tog_enable_i, // Toggle enable
	input wire logic                    tog_settle_i, // Settle pulse
	input wire pdts_tog_result_type     tog_result_i, // Settle result
	input wire pdts_rx_type             rx_i,         // Packet stored
	input wire pdts_event_type          events_i,     // Event strobes
	input wire logic [`PDTS_DATA_W-1:0] rd_data_o,    // Read data
	input wire logic                    rd_valid_o,   // Read valid
	input wire logic                    irq_n_o,      // Interrupt
	input wire pdts_tog_result_type     stop_state_o, // Stop state
	input wire logic                    stopped_o     // Engine stopped
);
	// ----------------------------------------------------------------
	// Shadow of masks and of a clearing read
	// ----------------------------------------------------------------
	logic [7:0] mask_a_q;
	logic       mask_b_q;
	logic       clr_seen_q;
	wire logic rd_a = req_i.rd && req_i.addr == `PDTS_ADDR_LATCH_A;
	wire logic rd_b = req_i.rd && req_i.addr == `PDTS_ADDR_LATCH_B;
	wire logic rd_s = req_i.rd && req_i.addr == `PDTS_ADDR_STATUS;
	wire logic evt_a = (|events_i[8:1]) || tog_settle_i;
	wire logic run_ok = tog_settle_i && tog_enable_i && !stopped_o;
	wire logic all_masked = (&mask_a_q) && mask_b_q;
	wire logic [7:0] mask_a_d = (req_i.wr && req_i.addr == `PDTS_ADDR_MASK_A) ? req_i.wdata : mask_a_q;
	wire logic mask_b_d = (req_i.wr && req_i.addr == `PDTS_ADDR_MASK_B) ? req_i.wdata[0] : mask_b_q;
	// Any latch A set event (not ack_sent) spoils the promise that the latch is empty
	wire logic clr_seen_d = evt_a ? 1'b0 : (rd_a ? 1'b1 : clr_seen_q);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mask_a_q   <= 8'h00;
			mask_b_q   <= 1'b0;
			clr_seen_q <= 1'b0;
		end else begin
			mask_a_q   <= mask_a_d;
			mask_b_q   <= mask_b_d;
			clr_seen_q <= clr_seen_d;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	AST_RESET_VALUES: assert property ($past(sys_rst_i) |-> irq_n_o && !rd_valid_o && !stopped_o && rd_data_o == 8'h00)
		else $error("outputs not at reset values");
	AST_RD_ANSWER: assert property (req_i.rd |=> rd_valid_o)
		else $error("read not answered next cycle");
	AST_RD_CLEARS: assert property (rd_a && clr_seen_q |=> rd_data_o == 8'h00)
		else $error("latch a not cleared by read");
	AST_HARD_RX_LATCH: assert property (events_i.hard_rx ##1 rd_a |=> rd_data_o[`PDTS_IA_HARD_RX])
		else $error("hard reset received not latched");
	AST_OCP_LATCH: assert property ((events_i.ocp || events_i.over_temp) ##1 rd_a |=> rd_data_o[7])
		else $error("over-current or heat not latched");
	AST_ACK_SENT_LATCH: assert property (events_i.ack_sent ##1 rd_b |=> rd_data_o == 8'h01)
		else $error("ack sent not latched");
	AST_IRQ_RAISE: assert property (events_i.hard_rx && !mask_a_q[0] && !req_i.wr |-> ##2 !irq_n_o)
		else $error("interrupt not raised");
	AST_IRQ_MASKED: assert property (all_masked && $past(all_masked) |-> irq_n_o)
		else $error("interrupt raised while all masked");
	AST_TOG_STOP: assert property (run_ok && $past(tog_enable_i) |=> stopped_o)
		else $error("toggle did not stop on settle");
	AST_STOP_AUDIO: assert property (run_ok && $past(tog_enable_i) && tog_result_i == PDTS_RES_AUDIO
		|=> stop_state_o == PDTS_RES_SRC_CC1) else $error("audio stop state wrong");
	AST_STOP_STATE: assert property (run_ok && $past(tog_enable_i) && tog_result_i != PDTS_RES_AUDIO
		|=> stop_state_o == $past(tog_result_i)) else $error("stop state wrong");
	AST_RX_SOP: assert property (rx_i.stored && rx_i.kind == PDTS_SOP ##1 rd_s |=> rd_data_o[2:0] == 3'b001)
		else $error("sop flag wrong");

	COV_CLEAR_READ: cover property (rd_a ##1 rd_valid_o);
	COV_SETTLE: cover property (run_ok);
	COV_IRQ: cover property (!irq_n_o);
endmodule

bind pdts_top pdts_top_sva u_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
	.tog_enable_i(tog_enable_i), .tog_settle_i(tog_settle_i), .tog_result_i(tog_result_i),
	.rx_i(rx_i), .events_i(events_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
	.irq_n_o(irq_n_o), .stop_state_o(stop_state_o), .stopped_o(stopped_o));

// ==== verif/pdts_top_test.sv ====
// Self-checking testbench of the toggle status and event latch block
`timescale 1ns/1ns
`include "pdts_params.svh"
module pdts_top_test
	import pdts_pkg::*;
;
	logic                clk_i;
	logic                sys_rst_i;
	pdts_reg_req_type    req;
	logic                tog_en;
	pdts_event_type      events;
	logic                settle;
	pdts_tog_result_type result;
	pdts_rx_type         rx;
	logic [7:0]          rd_data;
	logic                rd_valid;
	logic                irq_n;
	pdts_tog_result_type stop_state;
	logic                stopped;
	int                  err_count;
	int                  check_count;
	pdts_tog_result_type res_tab [5] = '{PDTS_RES_SRC_CC1, PDTS_RES_SRC_CC2, PDTS_RES_SNK_CC1,
		PDTS_RES_SNK_CC2, PDTS_RES_AUDIO};
	logic [2:0]          code_tab [5] = '{`PDTS_TOG_SRC_CC1, `PDTS_TOG_SRC_CC2, `PDTS_TOG_SNK_CC1,
		`PDTS_TOG_SNK_CC2, `PDTS_TOG_AUDIO};

	pdts_far_model far (.clk_i(clk_i), .events_o(events), .tog_settle_o(settle), .tog_result_o(result),
		.rx_o(rx));
	pdts_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .tog_enable_i(tog_en),
		.tog_settle_i(settle), .tog_result_i(result), .rx_i(rx), .events_i(events), .rd_data_o(rd_data),
		.rd_valid_o(rd_valid), .irq_n_o(irq_n), .stop_state_o(stop_state), .stopped_o(stopped));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// Checks, verdict and register access
	// ----------------------------------------------------------------
	task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
		req = '{1'b0, 1'b1, addr, data};
		@(negedge clk_i);
		req = '0;
		@(negedge clk_i);
	endtask

	// The answer comes with the taking edge and is checked at the next falling edge; a missing one ends the run
	task automatic reg_rd(input string name, input logic [7:0] addr, input logic [7:0] exp);
		req = '{1'b1, 1'b0, addr, 8'h00};
		@(negedge clk_i);
		req = '0;
		chk_bit("read valid", 1'b1, rd_valid);
		if (rd_valid !== 1'b1) begin
			finish_test();
		end
		chk_byte(name, exp, rd_data);
		@(negedge clk_i);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		sys_rst_i = 1'b1;
		req = '0;
		tog_en = 1'b0;
		err_count = 0;
		check_count = 0;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		sys_rst_i = 1'b0;
		reg_rd("status", `PDTS_ADDR_STATUS, 8'h00);
		reg_rd("latch a", `PDTS_ADDR_LATCH_A, 8'h00);
		reg_rd("latch b", `PDTS_ADDR_LATCH_B, 8'h00);
		reg_rd("unmapped", 8'h10, 8'h00);
		chk_bit("irq", 1'b1, irq_n);
		for (int j = 0; j < 9; j++) begin
			far.pulse(9'h001 << j);
			// The pin drops one edge after the latch, while the read is in flight
			fork
				begin
					@(negedge clk_i);
					chk_bit("irq", 1'b0, irq_n);
				end
				if (j == 0) begin
					reg_rd("latch b", `PDTS_ADDR_LATCH_B, 8'h01);
				end else begin
					reg_rd("latch a", `PDTS_ADDR_LATCH_A, j > 6 ? 8'h80 : 8'h01 << (j - 1));
				end
			join
			reg_rd("cleared", j == 0 ? `PDTS_ADDR_LATCH_B : `PDTS_ADDR_LATCH_A, 8'h00);
			chk_bit("irq", 1'b1, irq_n);
		end
		reg_wr(`PDTS_ADDR_MASK_A, 8'hFF);
		reg_wr(`PDTS_ADDR_MASK_B, 8'hFF);
		reg_wr(`PDTS_ADDR_LATCH_A, 8'hFF);
		reg_rd("mask a", `PDTS_ADDR_MASK_A, 8'hFF);
		reg_rd("mask b", `PDTS_ADDR_MASK_B, 8'h01);
		far.pulse(9'h1FF);
		repeat (3) @(negedge clk_i);
		chk_bit("irq masked", 1'b1, irq_n);
		reg_wr(`PDTS_ADDR_MASK_A, 8'h00);
		chk_bit("irq unmasked", 1'b0, irq_n);
		reg_rd("latch a", `PDTS_ADDR_LATCH_A, 8'hBF);
		reg_rd("latch b", `PDTS_ADDR_LATCH_B, 8'h01);
		reg_wr(`PDTS_ADDR_MASK_B, 8'h00);
		fork
			far.pulse(9'h002);
			reg_rd("read with set", `PDTS_ADDR_LATCH_A, 8'h00);
		join
		reg_rd("survived", `PDTS_ADDR_LATCH_A, 8'h01);
		for (int i = 0; i < 5; i++) begin
			tog_en = 1'b0;
			@(negedge clk_i);
			tog_en = 1'b1;
			repeat (2) @(negedge clk_i);
			reg_rd("running", `PDTS_ADDR_STATUS, 8'h00);
			far.settle(res_tab[i]);
			reg_rd("code", `PDTS_ADDR_STATUS, {2'b00, code_tab[i], 3'b000});
			chk_bit("stopped", 1'b1, stopped);
			chk_byte("stop state", {5'h00, i == 4 ? PDTS_RES_SRC_CC1 : res_tab[i]}, {5'h00, stop_state});
			reg_rd("toggle done", `PDTS_ADDR_LATCH_A, 8'h40);
		end
		tog_en = 1'b0;
		@(negedge clk_i);
		far.settle(PDTS_RES_SNK_CC1);
		reg_rd("ignored settle", `PDTS_ADDR_LATCH_A, 8'h00);
		reg_rd("held code", `PDTS_ADDR_STATUS, 8'h38);
		for (int k = 0; k < 4; k++) begin
			far.store(pdts_sop_kind_type'(k));
			reg_rd("rx type", `PDTS_ADDR_STATUS, {5'b00111, k < 3 ? 3'b001 << k : 3'b000});
		end
		finish_test();
	end
endmodule
